// >>> rtl/gpio_pullup_and_function_select.sv
// Parallel I/O line controller with AXI4-Lite register slave
// Behaviour
// - Thirty-two lines, each at the same bit of every 32-bit register.
// - Pull-up status bit reads 1 when disabled, 0 when enabled.
// - Pull-up control works whatever owns the line.
// - After reset all pull-ups enabled; status reads zero.
// - Function enable/disable writes set/clear control status; 1 means general logic.
// - Control status 0 hands the pin to peripheral picked by A/B select.
// - Lines with no peripheral ignore function writes and read 1.
// - On general-only lines peripheral programming never drives the pin.
// - Control status reset value is a per-line parameter.
// - Register writes work while the controller clock is off.
// - Pin sampling and change detection only run with clock on.
// - Controller clock is off after reset until the power manager enables it.
// - Interrupt output only asserts while controller clock is on.
// - Every line has an input change interrupt.
// - Every line has an optional glitch filter.
// - Every line has a multi-drive open-drain mode.
// - One write updates up to 32 output bits through a write mask.
// - Pin inputs reach peripheral inputs unaltered.
// - A/B select bit 0 picks peripheral A, 1 picks peripheral B.
//
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module gpio_pullup_and_function_select
  import gpio_pkg::*;
#(
  parameter logic [31:0] MUX_MASK   = 32'hffff_ffff, // Lines with a peripheral
  parameter logic [31:0] CTRL_RESET = 32'hffff_ffff  // Control status reset
) (
  input  wire logic          aclk,       // System clock
  input  wire logic          aresetn,    // Sync reset, active low
  input  wire logic [AW-1:0] awaddr,     // Write address
  input  wire logic          awvalid,    // Write address valid
  output logic               awready,    // Write address ready
  input  wire logic [31:0]   wdata,      // Write data
  input  wire logic [3:0]    wstrb,      // Byte strobes
  input  wire logic          wvalid,     // Write data valid
  output logic               wready,     // Write data ready
  output logic [1:0]         bresp,      // Write response
  output logic               bvalid,     // Write response valid
  input  wire logic          bready,     // Write response ready
  input  wire logic [AW-1:0] araddr,     // Read address
  input  wire logic          arvalid,    // Read address valid
  output logic               arready,    // Read address ready
  output logic [31:0]        rdata,      // Read data
  output logic [1:0]         rresp,      // Read response
  output logic               rvalid,     // Read data valid
  input  wire logic          rready,     // Read data ready
  input  wire logic          pclk_en,    // Controller clock on, power manager
  input  wire logic [31:0]   pin_in,     // Pin levels
  output logic [31:0]        pin_out,    // Pin drive level
  output logic [31:0]        pin_oe,     // Pin drive enable
  output logic [31:0]        pullup_en,  // Pull-up resistor on
  input  periph_drive_t      periph_a,   // Peripheral A drive
  input  periph_drive_t      periph_b,   // Peripheral B drive
  output logic [31:0]        periph_in,  // Pin levels to peripherals
  output logic               irq         // Input change interrupt
);

  // Address match on word index
  function automatic logic hit(input logic [AW-1:0] a, input logic [7:0] off);
    return a[AW-1:2] == off[AW-1:2];
  endfunction

  // Set-then-clear update for enable/disable pairs
  function automatic logic [31:0] setclr(input logic [31:0] cur,
                                         input logic [31:0] s,
                                         input logic [31:0] c);
    return (cur | s) & ~c;
  endfunction

  logic              aw_hold_r;
  logic              w_hold_r;
  logic [AW-1:0]     waddr_r;
  logic [31:0]       wdata_r;
  logic [3:0]        wstrb_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              rvalid_r;
  logic [31:0]       rdata_r;
  logic [1:0]        rresp_r;
  logic              wr_go;
  logic [31:0]       wbits;
  logic              wr_ok;
  logic              rd_go;
  logic              rd_ok;
  logic [31:0]       rd_mux;
  logic              clk_on_r;
  logic [31:0]       ctrl_r;
  logic [31:0]       psr;
  logic [31:0]       absr_r;
  logic [31:0]       pusr_r;
  logic [31:0]       osr_r;
  logic [31:0]       odsr_r;
  logic [31:0]       owsr_r;
  logic [31:0]       mdsr_r;
  logic [31:0]       ifsr_r;
  logic [31:0]       imr_r;
  logic [31:0]       isr_r;
  logic [31:0]       samp_r;
  logic [31:0]       filt_r;
  logic [31:0]       prev_r;
  logic [31:0]       pdsr_r;
  logic [31:0]       pin_out_r;
  logic [31:0]       pin_oe_r;
  logic [31:0]       drv_lvl;
  logic [31:0]       drv_en;
  logic [31:0]       change;

  // Write channel: address and data taken in either order, one at a time
  assign awready = !aw_hold_r && !bvalid_r;
  assign wready  = !w_hold_r && !bvalid_r;
  assign wr_go   = aw_hold_r && w_hold_r && !bvalid_r;
  assign wbits   = wdata_r & {{8{wstrb_r[3]}}, {8{wstrb_r[2]}},
                              {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  assign bvalid  = bvalid_r;
  assign bresp   = bresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      waddr_r   <= '0;
      wdata_r   <= ZERO_RST;
      wstrb_r   <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_hold_r <= 1'b1;
        waddr_r   <= awaddr;
      end else if (wr_go) begin
        aw_hold_r <= 1'b0;
      end
      if (wvalid && wready) begin
        w_hold_r <= 1'b1;
        wdata_r  <= wdata;
        wstrb_r  <= wstrb;
      end else if (wr_go) begin
        w_hold_r <= 1'b0;
      end
    end
  end

  // Writable offsets; anything else answers with a slave error
  always_comb begin
    case (waddr_r[7:0])
      CTL_EN, CTL_DIS, OE_EN, OE_DIS, FLT_EN, FLT_DIS,
      OD_SET, OD_CLR, OD_STA, IC_EN, IC_DIS, MD_EN, MD_DIS,
      PU_EN, PU_DIS, SEL_A, SEL_B, OW_EN, OW_DIS: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_ok ? RESP_OKAY : RESP_SLV;
    end else if (bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Read channel: one outstanding read, data registered
  assign arready = !rvalid_r;
  assign rd_go   = arvalid && arready;
  assign rvalid  = rvalid_r;
  assign rdata   = rdata_r;
  assign rresp   = rresp_r;

  always_comb begin
    rd_ok = 1'b1;
    case (araddr[7:0])
      CTL_STA: rd_mux = psr;
      OE_STA:  rd_mux = osr_r;
      FLT_STA: rd_mux = ifsr_r;
      OD_STA:  rd_mux = odsr_r;
      PIN_STA: rd_mux = pdsr_r;
      IC_MASK: rd_mux = imr_r;
      IC_STA:  rd_mux = isr_r;
      MD_STA:  rd_mux = mdsr_r;
      PU_STA:  rd_mux = pusr_r;
      SEL_STA: rd_mux = absr_r;
      OW_STA:  rd_mux = owsr_r;
      default: begin
        rd_mux = ZERO_RST;
        rd_ok  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= ZERO_RST;
      rresp_r  <= RESP_OKAY;
    end else if (rd_go) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_mux;
      rresp_r  <= rd_ok ? RESP_OKAY : RESP_SLV;
    end else if (rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // Controller clock state follows the power manager, off from reset
  always_ff @(posedge aclk) begin
    if (!aresetn) clk_on_r <= 1'b0;
    else          clk_on_r <= pclk_en;
  end

  // Line ownership; configuration needs no controller clock
  always_ff @(posedge aclk) begin
    if (!aresetn)
      ctrl_r <= CTRL_RESET;
    else if (wr_go && hit(waddr_r, CTL_EN))
      ctrl_r <= setclr(ctrl_r, wbits, ZERO_RST);
    else if (wr_go && hit(waddr_r, CTL_DIS))
      ctrl_r <= setclr(ctrl_r, ZERO_RST, wbits);
  end
  // Lines without a peripheral always read as general purpose
  assign psr = ctrl_r | ~MUX_MASK;

  // A/B select status, kept whatever the line owner
  always_ff @(posedge aclk) begin
    if (!aresetn)
      absr_r <= ZERO_RST;
    else if (wr_go && hit(waddr_r, SEL_A))
      absr_r <= setclr(absr_r, ZERO_RST, wbits);
    else if (wr_go && hit(waddr_r, SEL_B))
      absr_r <= setclr(absr_r, wbits, ZERO_RST);
  end

  // Pull-up status: 1 means disabled, independent of ownership
  always_ff @(posedge aclk) begin
    if (!aresetn)
      pusr_r <= ZERO_RST;
    else if (wr_go && hit(waddr_r, PU_EN))
      pusr_r <= setclr(pusr_r, ZERO_RST, wbits);
    else if (wr_go && hit(waddr_r, PU_DIS))
      pusr_r <= setclr(pusr_r, wbits, ZERO_RST);
  end
  assign pullup_en = ~pusr_r;

  // Output enable, multi-drive, filter and interrupt mask pairs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osr_r  <= ZERO_RST;
      mdsr_r <= ZERO_RST;
      ifsr_r <= ZERO_RST;
      imr_r  <= ZERO_RST;
      owsr_r <= ZERO_RST;
    end else if (wr_go) begin
      if (hit(waddr_r, OE_EN))  osr_r  <= setclr(osr_r, wbits, ZERO_RST);
      if (hit(waddr_r, OE_DIS)) osr_r  <= setclr(osr_r, ZERO_RST, wbits);
      if (hit(waddr_r, MD_EN))  mdsr_r <= setclr(mdsr_r, wbits, ZERO_RST);
      if (hit(waddr_r, MD_DIS)) mdsr_r <= setclr(mdsr_r, ZERO_RST, wbits);
      if (hit(waddr_r, FLT_EN)) ifsr_r <= setclr(ifsr_r, wbits, ZERO_RST);
      if (hit(waddr_r, FLT_DIS)) ifsr_r <= setclr(ifsr_r, ZERO_RST, wbits);
      if (hit(waddr_r, IC_EN))  imr_r  <= setclr(imr_r, wbits, ZERO_RST);
      if (hit(waddr_r, IC_DIS)) imr_r  <= setclr(imr_r, ZERO_RST, wbits);
      if (hit(waddr_r, OW_EN))  owsr_r <= setclr(owsr_r, wbits, ZERO_RST);
      if (hit(waddr_r, OW_DIS)) owsr_r <= setclr(owsr_r, ZERO_RST, wbits);
    end
  end

  // Output data: set/clear, or one masked write avoids transient mixes
  always_ff @(posedge aclk) begin
    if (!aresetn)
      odsr_r <= ZERO_RST;
    else if (wr_go && hit(waddr_r, OD_SET))
      odsr_r <= setclr(odsr_r, wbits, ZERO_RST);
    else if (wr_go && hit(waddr_r, OD_CLR))
      odsr_r <= setclr(odsr_r, ZERO_RST, wbits);
    else if (wr_go && hit(waddr_r, OD_STA))
      odsr_r <= (odsr_r & ~owsr_r) | (wdata_r & owsr_r);
  end

  // Pin sampling; with the clock off the last levels are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      samp_r <= ZERO_RST;
      filt_r <= ZERO_RST;
      prev_r <= ZERO_RST;
      pdsr_r <= ZERO_RST;
    end else if (clk_on_r) begin
      samp_r <= pin_in;
      // Filtered lines only move once a level holds for two samples
      filt_r <= (filt_r & ifsr_r & ~(pin_in ~^ samp_r))
              | (pin_in & ~(ifsr_r & ~(pin_in ~^ samp_r)));
      prev_r <= filt_r;
      pdsr_r <= filt_r;
    end
  end
  assign change = (filt_r ^ prev_r) & {NLINES{clk_on_r}};

  // Change status: cleared by reading it, a fresh change still wins
  always_ff @(posedge aclk) begin
    if (!aresetn)
      isr_r <= ZERO_RST;
    else if (rd_go && hit(araddr, IC_STA))
      isr_r <= change;
    else
      isr_r <= isr_r | change;
  end
  assign irq = clk_on_r && |(isr_r & imr_r);

  // Pin drive: owner chosen per line, open drain never drives high
  always_comb begin
    drv_lvl = (psr & odsr_r)
            | (~psr & ((absr_r & periph_b.out) | (~absr_r & periph_a.out)));
    drv_en  = (psr & osr_r)
            | (~psr & ((absr_r & periph_b.oe) | (~absr_r & periph_a.oe)));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_out_r <= ZERO_RST;
      pin_oe_r  <= ZERO_RST;
    end else begin
      pin_out_r <= drv_lvl & ~mdsr_r;
      pin_oe_r  <= drv_en & ~(mdsr_r & drv_lvl);
    end
  end
  assign pin_out = pin_out_r;
  assign pin_oe  = pin_oe_r;
  // Inputs bypass all configuration; pin_in is assigned straight to periph_in
  assign periph_in = pin_in;

  // Checks beside the logic they guard
  a_pullup_reset: assert property (@(posedge aclk)
    $rose(aresetn) |-> pusr_r == ZERO_RST && psr == (CTRL_RESET | ~MUX_MASK))
    else $error("pull-up or control status wrong after reset");

  a_pullup_dis: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go && hit(waddr_r, PU_DIS) |=> (pusr_r & $past(wbits)) == $past(wbits)
      && pullup_en == ~pusr_r)
    else $error("pull-up disable write lost");

  a_bit_keep: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go && hit(waddr_r, PU_EN) |=> (pusr_r & ~$past(wbits)) == ($past(pusr_r) & ~$past(wbits)))
    else $error("unwritten pull-up bits changed");

  a_gpio_only: assert property (@(posedge aclk) disable iff (!aresetn)
    (psr & ~MUX_MASK) == ~MUX_MASK)
    else $error("general-only line not reading 1");

  a_periph_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (~psr & ~absr_r & ~mdsr_r) != ZERO_RST |=>
      ((pin_oe ^ $past(periph_a.oe)) & $past(~psr & ~absr_r & ~mdsr_r)) == ZERO_RST
      && ((pin_out ^ $past(periph_a.out)) & $past(~psr & ~absr_r & ~mdsr_r)) == ZERO_RST)
    else $error("peripheral A not driving pins");

  a_clk_off: assert property (@(posedge aclk) disable iff (!aresetn)
    !clk_on_r |=> $stable(pdsr_r) && $stable(filt_r))
    else $error("pin levels sampled with clock off");

  a_irq_clk: assert property (@(posedge aclk) disable iff (!aresetn)
    !pclk_en |=> !irq)
    else $error("interrupt with controller clock off");

  a_isr_read: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_go && hit(araddr, IC_STA) |=> isr_r == $past(change) && rvalid)
    else $error("change status not cleared by read");

  a_sync_out: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go && hit(waddr_r, OD_STA) |=>
      odsr_r == (($past(odsr_r) & ~$past(owsr_r)) | ($past(wdata_r) & $past(owsr_r))))
    else $error("masked output write wrong");

  a_open_drain: assert property (@(posedge aclk) disable iff (!aresetn)
    mdsr_r != ZERO_RST |=> (pin_out & $past(mdsr_r)) == ZERO_RST)
    else $error("multi-drive line driven high");

  a_cfg_no_clk: assert property (@(posedge aclk) disable iff (!aresetn)
    !clk_on_r && wr_go && hit(waddr_r, MD_EN) |=> (mdsr_r & $past(wbits)) == $past(wbits))
    else $error("configuration write lost with clock off");

endmodule

// >>> rtl/gpio_pkg.sv
// Register map, field widths and carrier types of the I/O line controller
package gpio_pkg;
  localparam int         NLINES    = 32;
  localparam int         AW        = 8;
  localparam logic [31:0] ZERO_RST = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLV  = 2'h2;

  // Byte offsets of the word registers
  localparam logic [7:0] CTL_EN   = 8'h00; // line_control_enable_reg
  localparam logic [7:0] CTL_DIS  = 8'h04; // line_control_disable_reg
  localparam logic [7:0] CTL_STA  = 8'h08; // line_control_status_reg
  localparam logic [7:0] OE_EN    = 8'h10;
  localparam logic [7:0] OE_DIS   = 8'h14;
  localparam logic [7:0] OE_STA   = 8'h18;
  localparam logic [7:0] FLT_EN   = 8'h20;
  localparam logic [7:0] FLT_DIS  = 8'h24;
  localparam logic [7:0] FLT_STA  = 8'h28;
  localparam logic [7:0] OD_SET   = 8'h30;
  localparam logic [7:0] OD_CLR   = 8'h34;
  localparam logic [7:0] OD_STA   = 8'h38;
  localparam logic [7:0] PIN_STA  = 8'h3c;
  localparam logic [7:0] IC_EN    = 8'h40;
  localparam logic [7:0] IC_DIS   = 8'h44;
  localparam logic [7:0] IC_MASK  = 8'h48;
  localparam logic [7:0] IC_STA   = 8'h4c;
  localparam logic [7:0] MD_EN    = 8'h50;
  localparam logic [7:0] MD_DIS   = 8'h54;
  localparam logic [7:0] MD_STA   = 8'h58;
  localparam logic [7:0] PU_EN    = 8'h60; // pullup_enable_reg
  localparam logic [7:0] PU_DIS   = 8'h64; // pullup_disable_reg
  localparam logic [7:0] PU_STA   = 8'h68; // pullup_status_reg
  localparam logic [7:0] SEL_A    = 8'h70;
  localparam logic [7:0] SEL_B    = 8'h74;
  localparam logic [7:0] SEL_STA  = 8'h78; // periph_ab_select_status
  localparam logic [7:0] OW_EN    = 8'h80;
  localparam logic [7:0] OW_DIS   = 8'h84;
  localparam logic [7:0] OW_STA   = 8'h88;

  // Output drive of one peripheral towards all lines
  typedef struct packed {
    logic [31:0] out;
    logic [31:0] oe;
  } periph_drive_t;
endpackage

// >>> verif/pin_periph_model.sv
// Pad and peripheral model facing the I/O line controller
`timescale 1ns/1ps
module pin_periph_model
  import gpio_pkg::*;
(
  input  wire logic    aclk,      // System clock
  input  wire logic [31:0] pin_out,   // Controller drive level
  input  wire logic [31:0] pin_oe,    // Controller drive enable
  input  wire logic [31:0] pullup_en, // Pull-up resistor on
  input  wire logic [31:0] ext_drv,   // Outside driver active
  input  wire logic [31:0] ext_val,   // Outside driver level
  output logic [31:0]  pin_in,    // Resolved pad level
  output periph_drive_t periph_a, // Peripheral A drive
  output periph_drive_t periph_b  // Peripheral B drive
);
  logic [31:0] float_r = 32'h0000_0000;

  // A released pad without pull-up keeps changing, so no stale level passes
  always @(posedge aclk) begin
    float_r <= ~float_r;
  end

  // Complementary patterns so peripheral A and B are told apart on a pin
  assign periph_a = {32'h5555_5555, 32'hffff_ffff};
  assign periph_b = {32'haaaa_aaaa, 32'hffff_ffff};

  // Own drive wins, then the outside driver, then pull-up or floating
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drv & ext_val)
                | (~pin_oe & ~ext_drv & (pullup_en | float_r));
endmodule

// >>> verif/tb_gpio_pullup_and_function_select.sv
// Self-checking bench for the I/O line controller
`timescale 1ns/1ps
module tb_gpio_pullup_and_function_select;
  import gpio_pkg::*;
  localparam logic [31:0] MUXED = 32'h0000_ffff; // Lines 16..31 general only
  localparam logic [31:0] CRST  = 32'hffff_fff0; // Lines 0..3 start on a peripheral

  logic          aclk    = 1'b0;
  logic          aresetn = 1'b0;
  logic [AW-1:0] awaddr  = '0;
  logic          awvalid = 1'b0;
  logic [31:0]   wdata   = '0;
  logic [3:0]    wstrb   = 4'hf;
  logic          wvalid  = 1'b0;
  logic          bready  = 1'b0;
  logic [AW-1:0] araddr  = '0;
  logic          arvalid = 1'b0;
  logic          rready  = 1'b0;
  logic          pclk_en = 1'b0;
  logic [31:0]   ext_drv = 32'hffff_ffff;
  logic [31:0]   ext_val = 32'h1234_5670;
  logic          awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]    bresp, rresp, rs;
  logic [31:0]   rdata, pin_in, pin_out, pin_oe, pullup_en, periph_in, rd;
  periph_drive_t periph_a, periph_b;
  int            error_cnt   = 0;
  int            checks_done = 0;

  always #4 aclk = ~aclk;

  gpio_pullup_and_function_select #(.MUX_MASK(MUXED), .CTRL_RESET(CRST))
    i_gpio_pullup_and_function_select (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .pclk_en(pclk_en), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pullup_en(pullup_en), .periph_a(periph_a), .periph_b(periph_b),
    .periph_in(periph_in), .irq(irq));

  pin_periph_model i_pin_periph_model (.aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pullup_en(pullup_en), .ext_drv(ext_drv), .ext_val(ext_val), .pin_in(pin_in),
    .periph_a(periph_a), .periph_b(periph_b));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Handshakes judged at the falling edge, where both sides are settled
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic aw_t, w_t, b_t;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(negedge aclk);
      aw_t = awvalid & awready;
      w_t = wvalid & wready;
      b_t = bvalid & bready;
      resp = bresp;
      @(posedge aclk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      if (b_t) begin
        bready <= 1'b0;
        return;
      end
    end
  endtask

  task automatic rd_t(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    logic ar_t, r_t;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(negedge aclk);
      ar_t = arvalid & arready;
      r_t = rvalid & rready;
      d = rdata;
      resp = rresp;
      @(posedge aclk);
      if (ar_t) arvalid <= 1'b0;
      if (r_t) begin
        rready <= 1'b0;
        return;
      end
    end
  endtask

  task automatic reg_is(input logic [7:0] a, input logic [31:0] exp, input string what);
    rd_t(a, rd, rs);
    check(what, rd, exp);
  endtask

  task automatic t_reset();
    check("pullup_en", pullup_en, 32'hffff_ffff);
    check("irq", {31'h0, irq}, 32'h0);
    reg_is(PU_STA, ZERO_RST, "pullup status");
    reg_is(CTL_STA, CRST, "control status");
    reg_is(SEL_STA, 32'h0, "select status");
  endtask

  // Clock still off here, and lines 0..3 belong to a peripheral
  task automatic t_pullup();
    wr(PU_DIS, 32'h0000_00a5, rs);
    check("write resp", {30'h0, rs}, {30'h0, RESP_OKAY});
    reg_is(PU_STA, 32'h0000_00a5, "pullup status");
    check("pullup_en", pullup_en, 32'hffff_ff5a);
    wr(PU_EN, 32'h0000_0001, rs);
    reg_is(PU_STA, 32'h0000_00a4, "pullup status");
    wr(PU_STA, 32'hffff_ffff, rs);
    check("read-only resp", {30'h0, rs}, {30'h0, RESP_SLV});
    reg_is(PU_STA, 32'h0000_00a4, "pullup status");
    rd_t(8'hfc, rd, rs);
    check("unmapped", {rs, rd[29:0]}, {RESP_SLV, 30'h0});
  endtask

  task automatic t_pins_irq();
    pclk_en <= 1'b1;
    wr(IC_EN, 32'hffff_ffff, rs);
    repeat (4) @(posedge aclk);
    reg_is(PIN_STA, 32'h1234_5675, "pin status");
    check("periph_in", periph_in, 32'h1234_5675);
    rd_t(IC_STA, rd, rs);
    check("irq cleared", {31'h0, irq}, 32'h0);
    ext_val <= 32'h1234_5770;
    repeat (5) @(posedge aclk);
    check("irq raised", {31'h0, irq}, 32'h1);
    reg_is(IC_STA, 32'h0000_0100, "change status");
    ext_val <= 32'h1234_5670;
    repeat (5) @(posedge aclk);
    pclk_en <= 1'b0;
    repeat (2) @(posedge aclk);
    check("irq clock off", {31'h0, irq}, 32'h0);
    ext_val <= 32'h1234_5270;
    repeat (5) @(posedge aclk);
    reg_is(PIN_STA, 32'h1234_5675, "frozen pin status");
  endtask

  task automatic t_function();
    wr(CTL_EN, 32'hffff_ffff, rs);
    reg_is(CTL_STA, 32'hffff_ffff, "control status");
    wr(CTL_DIS, 32'hffff_000c, rs);
    reg_is(CTL_STA, 32'hffff_fff3, "control status");
    wr(SEL_B, 32'h0000_0008, rs);
    reg_is(SEL_STA, 32'h0000_0008, "select status");
    repeat (2) @(posedge aclk);
    check("pin_oe", pin_oe, 32'h0000_000c);
    check("pin_out", pin_out, 32'h0000_000c);
  endtask

  // Output paths and open drain set up with the clock off, then the glitch filter
  task automatic t_output();
    wr(OE_EN, 32'h0000_00f0, rs);
    wr(OD_SET, 32'h0000_0030, rs);
    wr(OD_CLR, 32'h0000_0010, rs);
    reg_is(OE_STA, 32'h0000_00f0, "output enable status");
    reg_is(OD_STA, 32'h0000_0020, "output data status");
    check("pin_oe", pin_oe, 32'h0000_00fc);
    check("pin_out", pin_out, 32'h0000_002c);
    wr(OW_EN, 32'h0000_00c0, rs);
    wr(OD_STA, 32'h0000_00ff, rs);
    check("masked write resp", {30'h0, rs}, {30'h0, RESP_OKAY});
    reg_is(OD_STA, 32'h0000_00e0, "masked output data");
    wr(MD_EN, 32'h0000_0060, rs);
    reg_is(MD_STA, 32'h0000_0060, "multi-drive status");
    check("open drain out", pin_out, 32'h0000_008c);
    check("open drain oe", pin_oe, 32'h0000_009c);
    pclk_en <= 1'b1;
    wr(FLT_EN, 32'h0000_0100, rs);
    repeat (3) @(posedge aclk);
    rd_t(IC_STA, rd, rs);
    // A one-sample pulse on filtered line 8 must vanish
    ext_val <= 32'h1234_5370;
    @(posedge aclk);
    ext_val <= 32'h1234_5270;
    repeat (4) @(posedge aclk);
    reg_is(IC_STA, ZERO_RST, "glitch change status");
    reg_is(PIN_STA, 32'h1234_52ec, "glitch pin status");
    ext_val <= 32'h1234_5370;
    repeat (4) @(posedge aclk);
    reg_is(PIN_STA, 32'h1234_53ec, "filtered pin status");
    reg_is(IC_STA, 32'h0000_0100, "filtered change status");
  endtask

  task automatic end_of_test();
    $display("Checks %0d, errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Whole run is well under two hundred cycles; this margin only cuts a hang
  initial begin
    #100000;
    error_cnt++;
    end_of_test();
  end

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_pullup();
    t_pins_irq();
    t_function();
    t_output();
    end_of_test();
  end
endmodule
